// [src/paelc_regs.sv]
// Expansion status register and indicator configuration register of one port.
// Assumes reg_rd/reg_wr are one-cycle strobes from the management front end
// and that the status inputs come from port logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
// How it works
// RQ1: Parallel detection fault sets a sticky status bit, zero from reset.
// RQ2: Sticky status bits clear after a read unless the cause persists.
// RQ3: Three identical consecutive code words set sticky page received bit.
// RQ4: Partner next page ability is reported live, zero from reset.
// RQ5: Partner auto-negotiation ability is reported live, zero from reset.
// RQ6: Four user bits are plain storage with no effect.
// RQ7: Pulse tuning bit high selects fast rise time output.
// RQ8: Third indicator select: link, half duplex, 100 Mbps, collision.
// RQ9: Second indicator select: receive, link, half duplex, 100 Mbps.
// RQ10: First indicator select: transmit, receive, link, half duplex.
// RQ11: Extension bit zero stretches all indicators; one disables stretch.
module paelc_regs
  import paelc_pkg::*;
#(
  parameter int STRETCH = STRETCH_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  input wire logic pd_fault,
  input wire logic code_word_valid,
  input wire logic [15:0] code_word,
  input wire logic lp_next_page,
  input wire logic lp_an_able,
  input wire logic tx_act,
  input wire logic rx_act,
  input wire logic link_up,
  input wire logic half_duplex,
  input wire logic speed_100,
  input wire logic collision,
  output logic tx_fast_rise,
  output logic algo_select,
  output logic port_indicator_first,
  output logic port_indicator_second,
  output logic port_indicator_third
);
  logic [15:0] cfg_q;
  logic pdf_q;
  logic pr_q;
  logic [15:0] last_word_q;
  logic [1:0] match_q;
  logic page_hit;
  logic exp_rd;
  logic [2:0] ind_raw;
  logic [2:0] ind_q;

  function automatic logic pick(input logic [1:0] sel, input logic [3:0] src);
    pick = src[sel];
  endfunction : pick

  assign exp_rd = reg_rd && (reg_addr == EXP_ADDR);

  // RQ3 identical word run
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last_word_q <= 16'h0000;
      match_q <= 2'h0;
    end else if (code_word_valid) begin
      last_word_q <= code_word;
      if (match_q != 2'h0 && code_word == last_word_q) begin
        match_q <= (match_q == 2'(PAGE_MATCH_CNT)) ? match_q : match_q + 2'h1;
      end else begin
        match_q <= 2'h1;
      end
    end
  end
  assign page_hit = code_word_valid && match_q == 2'(PAGE_MATCH_CNT - 1)
                    && code_word == last_word_q;

  // RQ1 RQ2 sticky fault, set wins over read clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pdf_q <= 1'b0;
    end else if (pd_fault) begin
      pdf_q <= 1'b1;
    end else if (exp_rd) begin
      pdf_q <= 1'b0;
    end
  end

  // RQ3 RQ2 sticky page received
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pr_q <= 1'b0;
    end else if (page_hit) begin
      pr_q <= 1'b1;
    end else if (exp_rd) begin
      pr_q <= 1'b0;
    end
  end

  // RQ6 RQ7 configuration storage, reserved bits stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (reg_wr && reg_addr == LEDCFG_ADDR) begin
      cfg_q <= reg_wdata & CFG_WMASK;
    end
  end

  // RQ4 RQ5 read mux with live partner bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_q <= 16'h0000;
      if (reg_addr == EXP_ADDR) begin
        reg_rdata_q[EXP_PDF_BIT] <= pdf_q;
        reg_rdata_q[EXP_LPNP_BIT] <= lp_next_page;
        reg_rdata_q[EXP_PR_BIT] <= pr_q;
        reg_rdata_q[EXP_LPAN_BIT] <= lp_an_able;
      end else if (reg_addr == LEDCFG_ADDR) begin
        reg_rdata_q <= cfg_q;
      end
    end
  end

  // RQ7 pulse tuning
  assign tx_fast_rise = cfg_q[CFG_TXTUNE_BIT];
  assign algo_select = cfg_q[CFG_ALGO_BIT];

  // RQ10 RQ9 RQ8 indicator selection
  assign ind_raw[0] = pick(cfg_q[CFG_SEL0_LSB +: 2], {half_duplex, link_up, rx_act, tx_act});
  assign ind_raw[1] = pick(cfg_q[CFG_SEL1_LSB +: 2], {speed_100, half_duplex, link_up, rx_act});
  assign ind_raw[2] = pick(cfg_q[CFG_SEL2_LSB +: 2], {collision, speed_100, half_duplex, link_up});

  // RQ11 active time extension
  for (genvar i = 0; i < 3; i++) begin : g_str
    paelc_stretch #(.HOLD(STRETCH)) u_str (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .enable(!cfg_q[CFG_EXT_BIT]),
      .in_raw(ind_raw[i]),
      .out_q(ind_q[i])
    );
  end
  assign port_indicator_first = ind_q[0];
  assign port_indicator_second = ind_q[1];
  assign port_indicator_third = ind_q[2];

  property p_fault_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      pd_fault |=> pdf_q;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault bit not set"); // RQ1

  property p_read_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (exp_rd && !pd_fault && !page_hit) |=> (!pdf_q && !pr_q);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("sticky bits not cleared"); // RQ2

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (pdf_q && !exp_rd) |=> pdf_q;
  endproperty
  a_hold: assert property (p_hold) else $error("fault bit dropped"); // RQ1

  property p_page;
    @(posedge core_clk) disable iff (!rst_n)
      page_hit |=> pr_q;
  endproperty
  a_page: assert property (p_page) else $error("page bit not set"); // RQ3

  sequence s_exp_read;
    reg_rd && reg_addr == EXP_ADDR;
  endsequence
  property p_lpan;
    @(posedge core_clk) disable iff (!rst_n)
      s_exp_read |=> reg_rdata_q[EXP_LPAN_BIT] == $past(lp_an_able)
        && reg_rdata_q[EXP_LPNP_BIT] == $past(lp_next_page);
  endproperty
  a_lpan: assert property (p_lpan) else $error("partner bits wrong"); // RQ5

  property p_user;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == LEDCFG_ADDR) |=>
        cfg_q[CFG_USER_LSB +: 4] == $past(reg_wdata[CFG_USER_LSB +: 4]);
  endproperty
  a_user: assert property (p_user) else $error("user bits lost"); // RQ6

  // Checked against the written word so a broken storage path would show
  property p_tune;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == LEDCFG_ADDR) |=>
        tx_fast_rise == $past(reg_wdata[CFG_TXTUNE_BIT]) && cfg_q[11:9] == 3'h0;
  endproperty
  a_tune: assert property (p_tune) else $error("tuning output wrong"); // RQ7

  property p_third;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg_q[CFG_SEL2_LSB +: 2] == 2'h3 && collision) |=> port_indicator_third;
  endproperty
  a_third: assert property (p_third) else $error("collision not shown"); // RQ8

  property p_nostretch;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg_q[CFG_EXT_BIT] && $past(cfg_q[CFG_EXT_BIT]) && !ind_raw[0])
        |=> !port_indicator_first;
  endproperty
  a_nostretch: assert property (p_nostretch) else $error("stretch not disabled"); // RQ11
endmodule : paelc_regs
`default_nettype wire

// [pkg/paelc_pkg.sv]
// Constants for the expansion status and indicator configuration registers.
// Assumes a management front end that presents decoded register reads and writes.
package paelc_pkg;
  localparam logic [4:0] EXP_ADDR = 5'h06;
  localparam logic [4:0] LEDCFG_ADDR = 5'h10;
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LPNP_BIT = 3;
  localparam int EXP_PR_BIT = 1;
  localparam int EXP_LPAN_BIT = 0;
  localparam int CFG_USER_LSB = 12;
  localparam int CFG_TXTUNE_BIT = 8;
  localparam int CFG_SEL2_LSB = 6;
  localparam int CFG_SEL1_LSB = 4;
  localparam int CFG_SEL0_LSB = 2;
  localparam int CFG_ALGO_BIT = 1;
  localparam int CFG_EXT_BIT = 0;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'hF1FF;
  localparam int STRETCH_NS = 64000;
  localparam int CLK_NS = 8;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_W = 16;
  // Number of identical code words that make a received page
  localparam int PAGE_MATCH_CNT = 3;
endpackage : paelc_pkg

// [src/paelc_stretch.sv]
// Pulse stretcher for one indicator output.
// Assumes in_raw is synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module paelc_stretch #(
  parameter int HOLD = 8000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic in_raw,
  output logic out_q
);
  logic [15:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (in_raw) begin
      cnt_q <= 16'(HOLD);
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= in_raw | (enable & (cnt_q != 16'h0000));
    end
  end
endmodule : paelc_stretch
`default_nettype wire

// [testbench/paelc_mgmt.sv]
// Management controller model issuing register strobes.
// Assumes the design samples strobes on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module paelc_mgmt (
  input wire logic core_clk,
  output logic [4:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q
);
  initial begin
    reg_addr = 5'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // Stale data would hide a late sample
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask : rd
endmodule : paelc_mgmt
`default_nettype wire

// [testbench/phy_autoneg_expansion_led_config_tb.sv]
// Self-checking bench for the status and indicator registers.
// Assumes paelc_mgmt issues the register strobes.
`timescale 1ns/100ps
`default_nettype none
module phy_autoneg_expansion_led_config_tb;
  import paelc_pkg::*;
  localparam int HOLD = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pd_fault = 1'b0, cw_valid = 1'b0, lp_np = 1'b0, lp_an = 1'b0;
  logic [15:0] code_word = 16'h0000;
  logic [5:0] st = 6'h00;
  logic [4:0] reg_addr;
  logic reg_rd, reg_wr, tx_fast_rise;
  logic [15:0] reg_wdata, reg_rdata_q, v, r;
  wire [2:0] ind;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 32'h5765;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  paelc_mgmt mgmt (.core_clk(core_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
  paelc_regs #(.STRETCH(HOLD)) dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .pd_fault(pd_fault), .code_word_valid(cw_valid), .code_word(code_word),
    .lp_next_page(lp_np), .lp_an_able(lp_an), .tx_act(st[0]), .rx_act(st[1]),
    .link_up(st[2]), .half_duplex(st[3]), .speed_100(st[4]), .collision(st[5]),
    .tx_fast_rise(tx_fast_rise), .algo_select(), .port_indicator_first(ind[0]),
    .port_indicator_second(ind[1]), .port_indicator_third(ind[2]));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [2:0] sel_exp(input logic [15:0] c, input logic [5:0] s);
    return {s[c[7:6] + 2], s[c[5:4] + 1], s[c[3:2]]};
  endfunction : sel_exp
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // Far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0000);
    mgmt.rd(LEDCFG_ADDR, r);
    chk(r, CFG_RESET);
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      mgmt.wr(LEDCFG_ADDR, v);
      mgmt.wr(5'h11, ~v);
      mgmt.rd(LEDCFG_ADDR, r);
      chk(r, v & CFG_WMASK);
      chk({15'h0000, tx_fast_rise}, {15'h0000, v[8]});
      mgmt.rd(5'h11, r);
      chk(r, 16'h0000);
    end
    $display("config test done");
    for (int k = 0; k < 4; k++) begin
      v = {8'h00, 2'(k + 2), 2'(k + 1), 2'(k), 2'b01};
      mgmt.wr(LEDCFG_ADDR, v);
      repeat (8) begin
        @(negedge core_clk);
        st = 6'($random(seed));
        @(negedge core_clk);
        chk({13'h0000, ind}, {13'h0000, sel_exp(v, st)});
      end
    end
    $display("select test done");
    st = 6'h00;
    for (int e = 0; e < 2; e++) begin
      mgmt.wr(LEDCFG_ADDR, 16'(e));
      st = 6'h01;
      @(negedge core_clk);
      st = 6'h00;
      // Last stretched cycle, then the first dark one
      repeat (HOLD) @(negedge core_clk);
      chk({15'h0000, ind[0]}, 16'(1 - e));
      @(negedge core_clk);
      chk({15'h0000, ind[0]}, 16'h0000);
    end
    $display("stretch test done");
    pd_fault = 1'b1;
    lp_np = 1'b1;
    lp_an = 1'b1;
    @(negedge core_clk);
    pd_fault = 1'b0;
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0019);
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0009);
    pd_fault = 1'b1;
    mgmt.rd(EXP_ADDR, r);
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0019);
    pd_fault = 1'b0;
    lp_np = 1'b0;
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0011);
    lp_an = 1'b0;
    v = 16'($random(seed));
    for (int j = 0; j < 5; j++) begin
      @(negedge core_clk);
      code_word = (j < 2) ? v : ~v;
      cw_valid = 1'b1;
      @(negedge core_clk);
      cw_valid = 1'b0;
      if (j == 3) begin
        mgmt.rd(EXP_ADDR, r);
        chk(r, 16'h0000);
      end
    end
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0002);
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0000);
    $display("status test done");
    mgmt.wr(LEDCFG_ADDR, 16'hFFFF);
    pd_fault = 1'b1;
    @(negedge core_clk);
    rst_n = 1'b0;
    pd_fault = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    mgmt.rd(EXP_ADDR, r);
    chk(r, 16'h0000);
    mgmt.rd(LEDCFG_ADDR, r);
    chk(r, CFG_RESET);
    chk({13'h0000, ind}, 16'h0000);
    $display("reset test done");
    close_out();
  end
endmodule : phy_autoneg_expansion_led_config_tb
`default_nettype wire
